// ---- dac_serial_regs.vh ----
/*
  constants for the serial converter input block: word layout and timing.
  assumes a 10 MHz system clock and a serial clock sampled as a plain input.
*/
`ifndef DAC_SERIAL_REGS_VH
`define DAC_SERIAL_REGS_VH
`define WORD_BITS      24
`define CODE_BITS      16
`define CODE_LSB       0
`define PD_MSB         17
`define PD_LSB         16
`define PD_WIDTH       2
`define PD_NORMAL      2'h0
`define CODE_RESET     16'h0000
`define PD_RESET       2'h0
`define BIT_CNT_WIDTH  5
`define FIFO_DEPTH     4
`define SCLK_MAX_HZ    30000000
`endif

// ---- word_fifo.v ----
/*
  small synchronous fifo with valid/ready on both sides.
  assumes one clock; depth is a power of two.
*/
`timescale 1ns/1ps
module word_fifo #(
  parameter WIDTH = 24,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  input  wire             clk_in,
  input  wire             rst_in,
  input  wire             in_valid_in,
  output wire             in_ready_out,
  input  wire [WIDTH-1:0] in_data_in,
  output wire             out_valid_out,
  input  wire             out_ready_in,
  output wire [WIDTH-1:0] out_data_out
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW:0]      wr_q;
  reg [AW:0]      rd_q;
  wire            full;
  wire            empty;
  wire            push;
  wire            pop;

  assign empty = (wr_q == rd_q);
  assign full  = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  assign push  = in_valid_in && !full;
  assign pop   = out_ready_in && !empty;
  assign in_ready_out  = !full;
  assign out_valid_out = !empty;
  assign out_data_out  = mem_q[rd_q[AW-1:0]];

  always @(posedge clk_in)
  begin
    if (push)
    begin
      mem_q[wr_q[AW-1:0]] <= in_data_in;
    end
  end

  always @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      wr_q <= {(AW+1){1'b0}};
      rd_q <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
      begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop)
      begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end
endmodule // word_fifo

// ---- serial_dac_input_interface.v ----
/*
  serial input interface of a 16-bit converter: frame sync, shift clock,
  data in; 24-bit shift register, abort on early sync release, fifo between
  the link and the converter register.
  assumes frame sync, shift clock and data are asynchronous pins, sampled
  by mclk_in; shift clock must be slow enough to be seen (mclk/4 or less).
*/
`timescale 1ns/1ps
`include "dac_serial_regs.vh"
module serial_dac_input_interface #(
  parameter WORD_BITS  = `WORD_BITS,
  parameter CODE_BITS  = `CODE_BITS,
  parameter FIFO_DEPTH = `FIFO_DEPTH
) (
  input  wire                 mclk_in,
  input  wire                 rst_in,
  input  wire                 sync_n_in,
  input  wire                 sclk_in,
  input  wire                 sdata_in,
  output reg  [CODE_BITS-1:0] analog_output_code_out,
  output reg                  power_down_out,
  output reg  [1:0]           pd_mode_out,
  output reg                  update_out,
  output reg                  abort_out,
  output reg                  overflow_out
);
  reg [2:0]            sync_sr_q;
  reg [2:0]            sclk_sr_q;
  reg [1:0]            data_sr_q;
  reg [WORD_BITS-1:0]  shift_q;
  reg [`BIT_CNT_WIDTH-1:0] count_q;
  reg                  done_q;
  reg                  push_q;
  reg [WORD_BITS-1:0]  word_q;
  wire                 frame_on;
  wire                 frame_rise;
  wire                 sclk_fall;
  wire                 f_in_ready;
  wire                 f_out_valid;
  wire [WORD_BITS-1:0] f_out_data;
  wire                 f_pop;

  // stage 0 of each chain is read only by stage 1
  always @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      sync_sr_q <= 3'h7;
      sclk_sr_q <= 3'h0;
      data_sr_q <= 2'h0;
    end
    else
    begin
      sync_sr_q <= {sync_sr_q[1:0], sync_n_in};
      sclk_sr_q <= {sclk_sr_q[1:0], sclk_in};
      data_sr_q <= {data_sr_q[0], sdata_in};
    end
  end

  assign frame_on   = !sync_sr_q[1];
  assign frame_rise = sync_sr_q[1] && !sync_sr_q[2];
  assign sclk_fall  = sclk_sr_q[2] && !sclk_sr_q[1];

  // frame receiver
  always @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      shift_q   <= {WORD_BITS{1'b0}};
      count_q   <= {`BIT_CNT_WIDTH{1'b0}};
      done_q    <= 1'b0;
      push_q    <= 1'b0;
      word_q    <= {WORD_BITS{1'b0}};
      abort_out <= 1'b0;
      overflow_out <= 1'b0;
    end
    else
    begin
      abort_out <= 1'b0;
      overflow_out <= 1'b0;
      if (push_q && f_in_ready)
      begin
        push_q <= 1'b0;
      end
      if (!frame_on)
      begin
        // partial word dropped, nothing reaches the converter
        if (frame_rise && !done_q && count_q != {`BIT_CNT_WIDTH{1'b0}})
        begin
          abort_out <= 1'b1;
        end
        count_q <= {`BIT_CNT_WIDTH{1'b0}};
        done_q  <= 1'b0;
      end
      else if (sclk_fall && !done_q)
      begin
        shift_q <= {shift_q[WORD_BITS-2:0], data_sr_q[1]};
        if (count_q == WORD_BITS - 1)
        begin
          done_q  <= 1'b1;
          count_q <= {`BIT_CNT_WIDTH{1'b0}};
          // a full fifo with the previous word still pending in word_q loses the newest word rather than stalling the pins
          if (push_q && !f_in_ready)
          begin
            overflow_out <= 1'b1;
          end
          else
          begin
            word_q <= {shift_q[WORD_BITS-2:0], data_sr_q[1]};
            push_q <= 1'b1;
          end
        end
        else
        begin
          count_q <= count_q + 1'b1;
        end
      end
    end
  end

  word_fifo #(
    .WIDTH (WORD_BITS),
    .DEPTH (FIFO_DEPTH),
    .AW    ($clog2(FIFO_DEPTH))
  ) u_fifo (
    .clk_in        (mclk_in),
    .rst_in        (rst_in),
    .in_valid_in   (push_q),
    .in_ready_out  (f_in_ready),
    .in_data_in    (word_q),
    .out_valid_out (f_out_valid),
    .out_ready_in  (f_pop),
    .out_data_out  (f_out_data)
  );

  assign f_pop = f_out_valid;

  // converter register and power-down state
  always @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      analog_output_code_out <= `CODE_RESET;
      pd_mode_out            <= `PD_RESET;
      power_down_out         <= 1'b0;
      update_out             <= 1'b0;
    end
    else
    begin
      update_out <= 1'b0;
      if (f_pop)
      begin
        analog_output_code_out <= f_out_data[CODE_BITS-1:`CODE_LSB];
        pd_mode_out    <= f_out_data[`PD_MSB:`PD_LSB];
        power_down_out <= (f_out_data[`PD_MSB:`PD_LSB] != `PD_NORMAL);
        update_out     <= 1'b1;
      end
    end
  end
endmodule // serial_dac_input_interface

// ---- serial_dac_input_interface_props.sv ----
/* checker on the serial converter ports.
   assumes the pins move only on mclk_in edges. */
`timescale 1ns/1ps
module serial_dac_input_interface_props (
  input wire        mclk_in,
  input wire        rst_in,
  input wire        sync_n_in,
  input wire [15:0] analog_output_code_out,
  input wire        power_down_out,
  input wire [1:0]  pd_mode_out,
  input wire        update_out,
  input wire        abort_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  AST_CODE_HOLD: assert property (!update_out |-> $stable(analog_output_code_out))
    else $error("code moved");
  AST_PD_HOLD: assert property (!update_out |-> $stable(pd_mode_out))
    else $error("mode moved");
  AST_PD_LEVEL: assert property (power_down_out == (pd_mode_out != 2'h0))
    else $error("power level");
  AST_UPD_PULSE: assert property (update_out |=> !update_out)
    else $error("long update");
  AST_ABORT_EXCL: assert property (abort_out |-> !update_out)
    else $error("abort updated");
  AST_ABORT_SYNC: assert property (abort_out |-> $past(sync_n_in, 2))
    else $error("abort in frame");
  AST_UPD_FRAME: assert property (update_out |-> !$past(sync_n_in, 5))
    else $error("update off frame");
  AST_IDLE_QUIET: assert property (sync_n_in [*8] |=> !update_out)
    else $error("idle update");
endmodule // serial_dac_input_interface_props
bind serial_dac_input_interface serial_dac_input_interface_props u_props (.*);

// ---- serial_master_model.sv ----
/* serial master model: frames words on sync, shift clock and data.
   assumes a 100 ns clk_in; shift clock 800 ns, idle high. */
`timescale 1ns/1ps
module serial_master_model (
  input  wire  clk_in,
  output logic sync_n_out = 1'b1,
  output logic sclk_out   = 1'b1,
  output logic sdata_out  = 1'b0
);
  task automatic hold(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // msb first; sync stays low a full period so the last fall is seen
  task automatic send(input logic [31:0] w, input int n);
    sync_n_out <= 1'b0;
    hold(4);
    for (int i = 0; i < n; i++)
    begin
      sdata_out <= w[n-1-i];
      hold(4);
      sclk_out <= 1'b0;
      hold(4);
      sclk_out <= 1'b1;
    end
    hold(8);
    sync_n_out <= 1'b1;
    sdata_out  <= ~sdata_out;
    hold(8);
  endtask
endmodule // serial_master_model

// ---- tb_serial_dac_input_interface.sv ----
/* self-checking bench for serial_dac_input_interface.
   assumes the master model owns the three link pins. */
`timescale 1ns/1ps
module tb_serial_dac_input_interface;
  logic       mclk_in = 1'b0;
  logic       rst_in  = 1'b1;
  wire        sync_n, sclk, sdata, pd, upd, abrt, ovf;
  wire [15:0] code;
  wire [1:0]  mode;
  int         n_errors = 0, compares = 0, n_upd = 0, n_abort = 0, n_ovf = 0;
  initial forever #50 mclk_in = ~mclk_in;
  always @(posedge mclk_in)
  begin
    if (upd === 1'b1) n_upd++;
    if (abrt === 1'b1) n_abort++;
    if (ovf === 1'b1) n_ovf++;
  end
  serial_master_model u_serial_master_model (.clk_in(mclk_in), .sync_n_out(sync_n),
    .sclk_out(sclk), .sdata_out(sdata));
  serial_dac_input_interface u_serial_dac_input_interface (.mclk_in(mclk_in),
    .rst_in(rst_in), .sync_n_in(sync_n), .sclk_in(sclk), .sdata_in(sdata),
    .analog_output_code_out(code), .power_down_out(pd), .pd_mode_out(mode),
    .update_out(upd), .abort_out(abrt), .overflow_out(ovf));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task complete_run;
    if (n_errors == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task t_reset;
    rst_in <= 1'b1;
    repeat (5) @(posedge mclk_in);
    rst_in <= 1'b0;
    repeat (3) @(posedge mclk_in);
    chk({pd, mode, code}, 32'h0);
  endtask
  task t_write(input logic [23:0] w);
    int u;
    u = n_upd;
    u_serial_master_model.send({8'h0, w}, 24);
    chk(n_upd, u + 1);
    chk({pd, mode, code}, {w[17:16] != 2'h0, w[17:0]});
    chk(n_ovf, 0);
  endtask
  // aborted word must leave the previous code in place
  task t_abort(input logic [15:0] old);
    int u, a;
    u = n_upd;
    a = n_abort;
    u_serial_master_model.send(32'h00beef, 23);
    chk(n_upd, u);
    chk(n_abort, a + 1);
    chk(code, old);
  endtask
  // two surplus falls after the word must neither start a word nor abort
  task t_extra;
    int u, a;
    u = n_upd;
    a = n_abort;
    u_serial_master_model.send({6'h0, 24'h01a55a, 2'b11}, 26);
    chk(n_upd, u + 1);
    chk(n_abort, a);
    chk({pd, mode, code}, 32'h5a55a);
  endtask
  initial
  begin
    t_reset;
    for (int k = 0; k < 4; k++)
      t_write({6'h0, k[1:0], 16'h8001 + k[15:0]});
    t_abort(16'h8004);
    t_extra;
    t_reset;
    complete_run;
  end
  initial
  begin
    #1_000_000;
    n_errors++;
    complete_run;
  end
endmodule // tb_serial_dac_input_interface
